// ===== core/osc_sel_cfg.svh
/*
 * Constants of the internal oscillator clock selector: register offsets,
 * field positions, reset values and switch timing.
 * Assumes a 20 MHz system clock; times are in nanoseconds.
 */
`ifndef OSC_SEL_CFG_SVH
`define OSC_SEL_CFG_SVH

`define ADR_CTRL       3'h0
`define ADR_STATUS     3'h1
`define ADR_INT_STS    3'h2
`define ADR_INT_CLR    3'h3
`define ADR_INT_EN     3'h4

`define CTRL_PLL_BIT   7
`define CTRL_FREQ_MSB  6
`define CTRL_FREQ_LSB  3
`define CTRL_SCS_MSB   1
`define CTRL_SCS_LSB   0
`define STS_PLL_BIT    6
`define STS_HFR_BIT    4
`define STS_LFR_BIT    1
`define STS_HFS_BIT    0

`define FREQ_RST       4'h7
`define SCS_RST        2'h0
`define CFG_INT        2'h0

`define INT_DONE_BIT   0
`define INT_PLL_BIT    1
`define INT_HFS_BIT    2

`define CLK_PERIOD_NS  50
`define HF_START_NS    2000
`define PLL_START_NS   2000000
`define EC_START_CYC   2
`define HF_START_CYC   ((`HF_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_START_CYC  ((`PLL_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/osc_sel_pkg.sv
/*
 * Types of the internal oscillator clock selector.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package osc_sel_pkg;

  typedef enum logic [2:0] {
    SRC_EXT,
    SRC_LF,
    SRC_MF,
    SRC_HF,
    SRC_PLL
  } clk_src_t;

  typedef struct packed {
    clk_src_t   src;
    logic [3:0] freq_select;
    logic [1:0] ext_power;
  } clk_sel_t;

  typedef struct packed {
    logic       pll_enable;
    logic [3:0] freq_select;
    logic [1:0] clk_source_select;
  } ctrl_t;

  typedef struct packed {
    logic pll;
    logic hf_ready;
    logic lf_ready;
    logic hf_stable;
  } osc_ind_t;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_STARTUP,
    SW_WAIT_FALL
  } sw_state_t;

endpackage

// ===== core/osc_clock_select.sv
/*
 * Internal oscillator clock selector: control and status registers, the
 * source and frequency decode, and the start-up-then-falling-edge handover.
 * Assumes the analog oscillators, PLL and glitch-free mux sit outside;
 * CLK_FALL is a one-cycle pulse per falling edge of the current system clock.
 */
`include "osc_sel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module osc_clock_select
  import osc_sel_pkg::*;
#(
  parameter int unsigned CNT_W         = 16,
  parameter int unsigned PLL_DELAY_CYC = `PLL_START_CYC
) (
  input  wire  logic                  SYS_CLK,
  input  wire  logic                  RSTN,
  input  wire  logic [2:0]            ADDR,
  input  wire  logic [7:0]            WDATA,
  input  wire  logic                  WR,
  input  wire  logic                  RD,
  output logic       [7:0]            RDATA,
  input  wire  logic [1:0]            CFG_OSC_SEL,
  input  wire  osc_sel_pkg::osc_ind_t OSC_IND,
  input  wire  logic                  CLK_FALL,
  output osc_sel_pkg::clk_sel_t       CLK_SEL,
  output logic                        HF_EN,
  output logic                        LF_EN,
  output logic                        PLL_ON,
  output logic                        SWITCHING,
  output logic                        IRQ
);
  import osc_sel_pkg::*;

  localparam logic [CNT_W-1:0] HF_CYC  = CNT_W'(`HF_START_CYC);
  localparam logic [CNT_W-1:0] EC_CYC  = CNT_W'(`EC_START_CYC);
  localparam logic [CNT_W-1:0] PLL_CYC = CNT_W'(PLL_DELAY_CYC);

  typedef struct packed {
    ctrl_t            ctrl;
    osc_ind_t         sync1;
    osc_ind_t         sync2;
    osc_ind_t         prev;
    sw_state_t        state;
    clk_sel_t         active;
    clk_sel_t         target;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       int_sts;
    logic [2:0]       int_en;
    logic [7:0]       rdata;
    logic             hf_en;
    logic             lf_en;
    logic             pll_on;
    logic             switching;
    logic             irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  // oscillator behind a frequency code; upper duplicates stay on hf
  function automatic clk_src_t freq_src(input logic [3:0] f);
    if (f[3]) begin
      return SRC_HF;
    end else if (f[2:1] == 2'h0) begin
      return SRC_LF;
    end else begin
      return SRC_MF;
    end
  endfunction

  // requested selection from the control bits and the configuration default
  function automatic clk_sel_t want_sel(input ctrl_t c, input logic [1:0] cfg);
    clk_sel_t r;
    r.freq_select = c.freq_select;
    r.ext_power   = cfg;
    if (!c.clk_source_select[1] && cfg != `CFG_INT) begin
      r.src = SRC_EXT;
    end else if (!c.clk_source_select[1] && c.pll_enable) begin
      r.src = SRC_PLL;
    end else begin
      r.src = freq_src(c.freq_select);
    end
    return r;
  endfunction

  function automatic logic uses_hf(input clk_src_t x);
    return (x == SRC_HF) || (x == SRC_MF) || (x == SRC_PLL);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  clk_sel_t want;
  logic     done;
  logic     ev_pll;
  logic     ev_hfs;

  always_comb begin
    s_d    = s_q;
    want   = want_sel(s_q.ctrl, CFG_OSC_SEL);
    done   = 1'b0;
    // raw indications are asynchronous; only sync2 and its one-cycle-delayed copy prev are looked at
    s_d.sync1 = OSC_IND;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    ev_pll = s_q.sync2.pll & ~s_q.prev.pll;
    ev_hfs = s_q.sync2.hf_stable & ~s_q.prev.hf_stable;

    if (WR && ADDR == `ADR_CTRL) begin
      s_d.ctrl.pll_enable        = WDATA[`CTRL_PLL_BIT];
      s_d.ctrl.freq_select       = WDATA[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB];
      s_d.ctrl.clk_source_select = WDATA[`CTRL_SCS_MSB:`CTRL_SCS_LSB];
    end
    if (WR && ADDR == `ADR_INT_EN) begin
      s_d.int_en = WDATA[2:0];
    end

    case (s_q.state)
      SW_IDLE: begin
        if (want != s_q.active) begin
          s_d.target = want;
          s_d.cnt    = '0;
          if (want.src == s_q.active.src) begin
            s_d.state = SW_WAIT_FALL;
          end else begin
            s_d.state = SW_STARTUP;
            case (want.src)
              SRC_HF, SRC_MF: s_d.cnt = s_q.sync2.hf_ready ? '0 : HF_CYC;
              SRC_EXT:        s_d.cnt = EC_CYC;
              SRC_PLL:        s_d.cnt = PLL_CYC;
              default:        s_d.cnt = '0;
            endcase
          end
        end
      end
      SW_STARTUP: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else if (s_q.target.src != SRC_LF || s_q.sync2.lf_ready) begin
          s_d.state = SW_WAIT_FALL;
        end
      end
      SW_WAIT_FALL: begin
        if (CLK_FALL) begin
          s_d.active = s_q.target;
          s_d.state  = SW_IDLE;
          done       = 1'b1;
        end
      end
      default: begin
        s_d.state = SW_IDLE;
      end
    endcase

    // oscillators run while in use or while being switched to
    s_d.hf_en  = uses_hf(s_d.active.src) ||
                 (s_d.state != SW_IDLE && uses_hf(s_d.target.src));
    s_d.lf_en  = (s_d.active.src == SRC_LF) ||
                 (s_d.state != SW_IDLE && s_d.target.src == SRC_LF);
    s_d.pll_on    = s_d.ctrl.pll_enable;
    s_d.switching = (s_d.state != SW_IDLE);

    // clear first so that a same-cycle event survives
    if (WR && ADDR == `ADR_INT_CLR) begin
      s_d.int_sts = s_q.int_sts & ~WDATA[2:0];
    end
    if (done) begin
      s_d.int_sts[`INT_DONE_BIT] = 1'b1;
    end
    if (ev_pll) begin
      s_d.int_sts[`INT_PLL_BIT] = 1'b1;
    end
    if (ev_hfs) begin
      s_d.int_sts[`INT_HFS_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.int_sts & s_d.int_en);

    s_d.rdata = 8'h00;
    if (RD) begin
      if (ADDR == `ADR_CTRL) begin
        s_d.rdata = {s_q.ctrl.pll_enable, s_q.ctrl.freq_select, 1'b0,
                     s_q.ctrl.clk_source_select};
      end else if (ADDR == `ADR_STATUS) begin
        s_d.rdata[`STS_PLL_BIT] = s_q.sync2.pll;
        s_d.rdata[`STS_HFR_BIT] = s_q.sync2.hf_ready;
        s_d.rdata[`STS_LFR_BIT] = s_q.sync2.lf_ready;
        s_d.rdata[`STS_HFS_BIT] = s_q.sync2.hf_stable;
      end else if (ADDR == `ADR_INT_STS) begin
        s_d.rdata = {5'h00, s_q.int_sts};
      end else if (ADDR == `ADR_INT_EN) begin
        s_d.rdata = {5'h00, s_q.int_en};
      end else begin
        s_d.rdata = 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q                        <= '0;
      s_q.ctrl.freq_select       <= `FREQ_RST;
      s_q.ctrl.clk_source_select <= `SCS_RST;
      s_q.state                  <= SW_IDLE;
      s_q.active.src             <= SRC_EXT;
      s_q.target.src             <= SRC_EXT;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA     = s_q.rdata;
  assign CLK_SEL   = s_q.active;
  assign HF_EN     = s_q.hf_en;
  assign LF_EN     = s_q.lf_en;
  assign PLL_ON    = s_q.pll_on;
  assign SWITCHING = s_q.switching;
  assign IRQ       = s_q.irq;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  reset_ctrl_a: assert property (
    @(posedge SYS_CLK) $rose(RSTN) |->
      s_q.ctrl.freq_select == 4'h7 && s_q.ctrl.pll_enable == 1'b0)
    else $error("control not at reset value after reset");

  reset_scs_a: assert property (
    @(posedge SYS_CLK) $rose(RSTN) |-> s_q.ctrl.clk_source_select == 2'h0)
    else $error("source select not cleared by reset");

  lf_decode_a: assert property (
    CLK_SEL.src == SRC_LF |-> CLK_SEL.freq_select[3:1] == 3'h0)
    else $error("lf source with a non-lf frequency code");

  hf_dup_a: assert property (
    (CLK_SEL.src == SRC_MF) |-> !CLK_SEL.freq_select[3])
    else $error("upper duplicate code running from mf path");

  // a switch into the pll may still finish, but the pll must be left at once
  pll_gate_a: assert property (
    s_q.state == SW_IDLE && CLK_SEL.src == SRC_PLL && s_q.ctrl.clk_source_select[1]
      |=> SWITCHING && s_q.target.src != SRC_PLL)
    else $error("pll kept while internal block selected");

  pll_follow_a: assert property (
    WR && ADDR == 3'h0 |=> PLL_ON == $past(WDATA[7]))
    else $error("pll enable does not follow control bit 7");

  same_src_a: assert property (
    s_q.state == SW_IDLE && want != s_q.active && want.src == s_q.active.src
      |=> s_q.state == SW_WAIT_FALL)
    else $error("same-source switch took a start-up delay");

  fall_done_a: assert property (
    s_q.state == SW_WAIT_FALL && CLK_FALL
      |=> s_q.state == SW_IDLE && CLK_SEL == $past(s_q.target) && !SWITCHING)
    else $error("switch did not complete on falling edge");

  // set beats a clear in the same cycle, so a completion is never lost
  done_flag_a: assert property (
    s_q.state == SW_WAIT_FALL && CLK_FALL |=> s_q.int_sts[`INT_DONE_BIT])
    else $error("switch completion not flagged");

  no_early_a: assert property (
    s_q.state == SW_WAIT_FALL && !CLK_FALL |=> CLK_SEL == $past(CLK_SEL))
    else $error("clock changed before falling edge");

  hf_wait_a: assert property (
    s_q.state == SW_IDLE && want.src == SRC_HF && s_q.active.src != SRC_HF
      && !s_q.sync2.hf_ready
      |=> s_q.state == SW_STARTUP ##1 s_q.state == SW_STARTUP [*8])
    else $error("hf start-up delay too short");

  ec_wait_a: assert property (
    s_q.state == SW_IDLE && want.src == SRC_EXT && s_q.active.src != SRC_EXT
      |=> s_q.state == SW_STARTUP [*3] ##1 s_q.state == SW_WAIT_FALL)
    else $error("external start-up not two cycles");

  pll_wait_a: assert property (
    s_q.state == SW_IDLE && want.src == SRC_PLL && s_q.active.src != SRC_PLL
      |=> s_q.state == SW_STARTUP && s_q.cnt == PLL_CYC)
    else $error("pll start-up delay not loaded");

  hf_ready_a: assert property (
    s_q.state == SW_IDLE && want.src != s_q.active.src && s_q.sync2.hf_ready
      && (want.src == SRC_HF || want.src == SRC_MF) |=> s_q.cnt == '0)
    else $error("start-up delay taken although hf oscillator runs");

  cnt_bound_a: assert property (
    s_q.cnt <= PLL_CYC || s_q.cnt <= HF_CYC)
    else $error("start-up counter out of range");

  ext_sel_a: assert property (
    !SWITCHING && s_q.state == SW_IDLE && s_q.ctrl.clk_source_select[1]
      && want == s_q.active |-> CLK_SEL.src != SRC_EXT)
    else $error("internal source selected but clock external");

  sts_sync_a: assert property (
    RD && ADDR == 3'h1 |=> RDATA[4] == $past(OSC_IND.hf_ready, 3))
    else $error("hf ready not two-flop synchronised");

  sts_bits_a: assert property (
    RD && ADDR == 3'h1 |=> RDATA[1] == $past(s_q.sync2.lf_ready)
      && RDATA[6] == $past(s_q.sync2.pll) && RDATA[0] == $past(s_q.sync2.hf_stable))
    else $error("status flags do not match oscillators");

  zero_bits_a: assert property (
    RD && (ADDR == 3'h0 || ADDR == 3'h1) |=>
      RDATA[2] == 1'b0 && ($past(ADDR) == 3'h0 ||
        RDATA[7] == 1'b0 && RDATA[5] == 1'b0 && RDATA[3] == 1'b0))
    else $error("unimplemented bit reads non-zero");

  irq_level_a: assert property (
    IRQ == |(s_q.int_sts & s_q.int_en))
    else $error("interrupt does not match enabled status");

endmodule

`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench for the internal oscillator clock selector.
 * Assumes osc_sel_pkg and osc_clock_select are compiled first and that
 * osc_sel_cfg.svh is on the include path.
 */
`include "osc_sel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  import osc_sel_pkg::*;

  // short pll count keeps the run brief; expectations use the same value
  localparam int PLL_CYC = 20;
  localparam logic [7:0] STS_MAP [4] = '{8'h01, 8'h02, 8'h10, 8'h40};

  logic       sys_clk      = 1'b0;
  logic       rstn         = 1'b0;
  logic [2:0] addr         = 3'h0;
  logic [7:0] wdata        = 8'h00;
  logic       wr           = 1'b0;
  logic       rd           = 1'b0;
  logic [1:0] cfg          = 2'h0;
  osc_ind_t   ind          = '0;
  logic       clk_fall     = 1'b0;
  logic [1:0] fall_cnt     = 2'h0;
  logic [7:0] rdata;
  clk_sel_t   sel;
  logic       hf_en;
  logic       lf_en;
  logic       pll_on;
  logic       switching;
  logic       irq;
  int         errors       = 0;
  int         total_checks = 0;
  logic [7:0] rv;
  int         n;

  osc_clock_select #(.PLL_DELAY_CYC(PLL_CYC)) dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CFG_OSC_SEL(cfg), .OSC_IND(ind), .CLK_FALL(clk_fall),
    .CLK_SEL(sel), .HF_EN(hf_en), .LF_EN(lf_en), .PLL_ON(pll_on),
    .SWITCHING(switching), .IRQ(irq)
  );

  always #25 sys_clk = ~sys_clk;

  // slow current clock: a falling edge only every fourth cycle, so the wait is visible
  always @(posedge sys_clk) begin
    fall_cnt <= fall_cnt + 2'h1;
    clk_fall <= (fall_cnt == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // waits out a switch; a request equal to the current one never raises the flag;
  // two quiet samples are needed since a chained switch leaves a one-cycle gap
  task automatic wait_done(output int c);
    int idle;
    c = 0;
    idle = 0;
    cyc(2);
    while (idle < 2 && c < 200) begin
      idle = (switching === 1'b0) ? idle + 1 : 0;
      cyc(1);
      c++;
    end
    if (c >= 200) errors++;
  endtask

  task automatic set_ind(input logic [3:0] v);
    @(posedge sys_clk);
    ind <= osc_ind_t'(v);
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(`ADR_CTRL, rv); chk(rv, 8'h38);
    rd_reg(`ADR_STATUS, rv); chk(rv, 8'h00);
    wait_done(n); chk({sel.src, sel.freq_select}, {SRC_MF, 4'h7});
  endtask

  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      set_ind(4'h1 << i);
      rd_reg(`ADR_STATUS, rv); chk(rv, STS_MAP[i]);
    end
  endtask

  task automatic t_decode;
    clk_src_t s;
    set_ind(4'h6);
    for (int f = 0; f < 16; f++) begin
      s = f[3] ? SRC_HF : (f < 2 ? SRC_LF : SRC_MF);
      wr_reg(`ADR_CTRL, {1'b0, 4'(f), 3'b110});
      wait_done(n); chk({sel.src, sel.freq_select}, {s, 4'(f)});
      rd_reg(`ADR_CTRL, rv); chk(rv, {1'b0, 4'(f), 3'b010});
    end
  endtask

  task automatic t_timing;
    set_ind(4'h2);
    wr_reg(`ADR_CTRL, 8'h02); wait_done(n); chk(lf_en, 1'b1);
    wr_reg(`ADR_CTRL, 8'h7A); wait_done(n);
    chk(n >= `HF_START_CYC - 2 && n <= `HF_START_CYC + 10, 1'b1);
    chk({sel.src, sel.freq_select, hf_en}, {SRC_HF, 4'hF, 1'b1});
    wr_reg(`ADR_CTRL, 8'h72); wait_done(n); chk(n <= 6, 1'b1);
    chk({sel.src, sel.freq_select}, {SRC_HF, 4'hE});
  endtask

  task automatic t_pll;
    wr_reg(`ADR_CTRL, 8'hF0); wait_done(n);
    chk(n >= PLL_CYC - 2 && n <= PLL_CYC + 10, 1'b1);
    chk({sel.src, sel.freq_select, pll_on}, {SRC_PLL, 4'hE, 1'b1});
    wr_reg(`ADR_CTRL, 8'hF2); wait_done(n); chk(sel.src, SRC_HF);
    wr_reg(`ADR_CTRL, 8'h70); wait_done(n); chk({sel.src, pll_on}, {SRC_HF, 1'b0});
  endtask

  task automatic t_ext;
    for (int c = 1; c < 4; c++) begin
      @(posedge sys_clk);
      cfg <= 2'(c);
      wr_reg(`ADR_CTRL, 8'h39);
      wait_done(n); chk({sel.src, sel.ext_power}, {SRC_EXT, 2'(c)});
    end
    wr_reg(`ADR_CTRL, 8'h3A); wait_done(n);
    chk({sel.src, sel.freq_select}, {SRC_MF, 4'h7});
  endtask

  task automatic t_irq;
    wr_reg(`ADR_INT_CLR, 8'h07);
    wr_reg(`ADR_INT_EN, 8'h01);
    rd_reg(`ADR_INT_EN, rv); chk({rv, irq}, {8'h01, 1'b0});
    wr_reg(`ADR_CTRL, 8'h32); wait_done(n); cyc(2); chk(irq, 1'b1);
    rd_reg(`ADR_INT_STS, rv); chk(rv[0], 1'b1);
    wr_reg(`ADR_INT_EN, 8'h00); cyc(2); chk(irq, 1'b0);
    wr_reg(`ADR_INT_EN, 8'h01); cyc(2); chk(irq, 1'b1);
    wr_reg(`ADR_INT_CLR, 8'h01); cyc(2); chk(irq, 1'b0);
    rd_reg(`ADR_INT_STS, rv); chk(rv, 8'h00);
    wr_reg(3'h5, 8'hFF); rd_reg(3'h5, rv); chk(rv, 8'h00);
    wr_reg(`ADR_STATUS, 8'hFF); rd_reg(`ADR_STATUS, rv); chk(rv, 8'h02);
  endtask

  task automatic t_rerun;
    wr_reg(`ADR_CTRL, 8'hFA);
    @(posedge sys_clk);
    rstn <= 1'b0;
    cyc(2);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd_reg(`ADR_CTRL, rv); chk(rv, 8'h38);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_status;
    t_decode;
    t_timing;
    t_pll;
    t_ext;
    t_irq;
    t_rerun;
    end_of_test;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_of_test;
  end
endmodule

`default_nettype wire
